// >>> bench/lvt_checker.sv
`timescale 1ns/10ps
module lvt_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Register bus
  input wire logic [lvt_pkg::LVT_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Core side
  input wire lvt_pkg::lvt_intr_type intr_o,
  input wire logic intr_valid_o,
  input wire logic intr_accept_i
);
  import lvt_pkg::*;
  logic wr_seen;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_seen <= 1'b0;
    end else if (avs_write_i) begin
      wr_seen <= 1'b1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_bus_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o)
    else $error("bus request not answered");
  a_bus_single: assert property (!avs_waitrequest_o && ce_i |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_caps_value: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_EXTENSION_CAPABILITY
    |-> avs_readdata_o == {8'h00, EXT_ENTRY_COUNT, 16'h0000})
    else $error("capability value wrong");
  a_unmapped_zero: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i[3:0] != 4'h0
    |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_valid_hold: assert property (
    intr_valid_o && !intr_accept_i |=> intr_valid_o && $stable(intr_o))
    else $error("delivery dropped before accept");
  a_valid_drop: assert property (intr_valid_o && intr_accept_i && ce_i |=> !intr_valid_o)
    else $error("delivery held after accept");
  a_masked_reset: assert property (!wr_seen |-> !intr_valid_o)
    else $error("interrupt before any unmask");
  a_msg_absent: assert property (
    intr_valid_o && !HAS_MSG[intr_o.source] |-> intr_o.msg_type == 3'h0)
    else $error("message type on entry without one");
  cover property (intr_valid_o && intr_accept_i);
  cover property (intr_valid_o && intr_o.source == 3'h0);
  cover property (avs_write_i && !avs_waitrequest_o);
endmodule

// >>> bench/lvt_core_model.sv
`timescale 1ns/10ps
module lvt_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Delivery handshake, accept after delay_i idle cycles
  input wire logic valid_i,
  input wire logic [3:0] delay_i,
  output logic accept_o
);
  logic [3:0] wait_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_q <= 4'h0;
      accept_o <= 1'b0;
    end else if (accept_o || !valid_i) begin
      wait_q <= 4'h0;
      accept_o <= 1'b0;
    end else if (wait_q >= delay_i) begin
      accept_o <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import lvt_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [LVT_AW-1:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic wt;
  logic vld;
  logic acc;
  logic [5:0] src = '0;
  logic [1:0] eoi = '0;
  logic [3:0] dly = 4'h0;
  logic ce = 1'b1;
  lvt_intr_type intr;
  lvt_intr_type exp_q[$];
  int err_count = 0;
  int samples_checked = 0;
  logic [2:0] legal [6][3] = '{'{0, 2, 4}, '{0, 2, 4}, '{0, 4, 7}, '{0, 4, 7}, '{0, 0, 0},
                               '{2, 4, 7}};
  logic [31:0] wm [7] = '{32'h0003_00ff, 32'h0001_07ff, 32'h0001_07ff, 32'h0001_a7ff,
                          32'h0001_a7ff, 32'h0001_00ff, 32'h0001_07ff};
  always #4 clk_i = ~clk_i;
  lvt_top dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .src_i(src), .intr_o(intr),
    .intr_valid_o(vld), .intr_accept_i(acc), .eoi_i(eoi));
  lvt_core_model core_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .valid_i(vld),
    .delay_i(dly), .accept_o(acc));
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    err_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk_word(input logic [31:0] e);
    samples_checked++;
    if (q !== e) fail($sformatf("read %h expected %h", q, e));
  endtask
  task automatic chk_ok(input logic c);
    samples_checked++;
    if (c !== 1'b1) fail("timer timing");
  endtask
  task automatic chk_intr;
    lvt_intr_type e;
    samples_checked++;
    e = 14'h3fff;
    if (exp_q.size() != 0) e = exp_q.pop_front();
    if (intr !== e) fail("interrupt mismatch");
  endtask
  always @(posedge clk_i) if (vld === 1'b1 && acc === 1'b1) chk_intr();
  task automatic bus(input logic w, input logic [LVT_AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk_i);
      n++;
    end while (wt !== 1'b0 && n < 40);
    if (n >= 40) begin
      fail("bus timeout");
      end_sim();
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic drain(input int lim);
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (exp_q.size() != 0) begin
      fail("interrupt missing");
      end_sim();
    end
  endtask
  task automatic pulse(input int b, input logic is_eoi);
    if (is_eoi) eoi[b] <= 1'b1;
    else src[b] <= 1'b1;
    @(posedge clk_i);
    eoi <= 2'b00;
    src[b] <= 1'b0;
  endtask
  initial begin
    int j;
    int t;
    int dv;
    logic [2:0] m;
    logic [7:0] v;
    logic [31:0] cfg;
    void'($urandom(52488));
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (j = 0; j < LVT_NUM; j++) begin
      bus(0, LVT_ENTRY_OFS[j], 0);
      chk_word(32'h0001_0000);
      cfg = $urandom;
      bus(1, LVT_ENTRY_OFS[j], cfg);
      bus(0, LVT_ENTRY_OFS[j], 0);
      chk_word(cfg & wm[j]);
      bus(1, LVT_ENTRY_OFS[j], 32'h0001_0000);
    end
    bus(0, OFS_TIMER_PRESENT_VALUE, 0);
    chk_word(32'h0);
    bus(0, OFS_TIMER_RELOAD_VALUE, 0);
    chk_word(RELOAD_RESET);
    bus(1, OFS_EXTENSION_CAPABILITY, '1);
    bus(0, OFS_EXTENSION_CAPABILITY, 0);
    chk_word(32'h0001_0000);
    bus(0, OFS_TIMER_PRESCALE_SELECT, 0);
    chk_word(32'h0);
    bus(1, OFS_TIMER_PRESCALE_SELECT, '1);
    bus(0, OFS_TIMER_PRESCALE_SELECT, 0);
    chk_word(32'h0000_000b);
    bus(1, 11'h004, '1);
    bus(0, 11'h004, 0);
    chk_word(32'h0);
    // Every source with each legal message type, slow core
    for (j = 1; j < LVT_NUM; j++) begin
      for (int r = 0; r < 3; r++) begin
        m = HAS_MSG[j] ? legal[j-1][r] : 3'h0;
        v = $urandom;
        cfg = {21'h0, m, v};
        dly <= 4'(7 + r * 4);
        bus(1, LVT_ENTRY_OFS[j], cfg);
        exp_q.push_back({3'(j), m, v});
        pulse(j - 1, 1'b0);
        bus(0, LVT_ENTRY_OFS[j], 0);
        chk_word(cfg | 32'h0000_1000);
        drain(40);
        bus(0, LVT_ENTRY_OFS[j], 0);
        chk_word(cfg);
      end
    end
    cfg = 32'h0001_0000 | v;
    bus(1, OFS_THERMAL_EVENT_ENTRY, cfg);
    pulse(0, 1'b0);
    repeat (10) @(posedge clk_i);
    bus(0, OFS_THERMAL_EVENT_ENTRY, 0);
    chk_word(cfg);
    // Level inputs with polarity set, prompt core
    dly <= 4'h0;
    for (j = 0; j < 2; j++) begin
      v = $urandom;
      cfg = {16'h0, 8'ha0, v};
      bus(1, LVT_ENTRY_OFS[ENT_INPUT0+j], cfg);
      exp_q.push_back({3'(ENT_INPUT0 + j), 3'h0, v});
      src[2+j] <= 1'b1;
      drain(40);
      bus(0, LVT_ENTRY_OFS[ENT_INPUT0+j], 0);
      chk_word(cfg | 32'h0000_4000);
      repeat (10) @(posedge clk_i);
      exp_q.push_back({3'(ENT_INPUT0 + j), 3'h0, v});
      pulse(j, 1'b1);
      drain(40);
      src[2+j] <= 1'b0;
      pulse(j, 1'b1);
      bus(0, LVT_ENTRY_OFS[ENT_INPUT0+j], 0);
      chk_word(cfg);
    end
    // One-shot timer at every prescale code
    for (j = 0; j < 8; j++) begin
      dv = (j == 7) ? 1 : 2 << j;
      v = $urandom;
      bus(1, OFS_TIMER_PRESCALE_SELECT, {28'h0, j[2], 1'b0, j[1:0]});
      bus(1, OFS_TIMER_ENTRY, {24'h0, v});
      exp_q.push_back({3'h0, 3'h0, v});
      bus(1, OFS_TIMER_RELOAD_VALUE, 32'h0000_0003);
      t = 0;
      while (vld !== 1'b1 && t < 600) begin
        @(posedge clk_i);
        t++;
      end
      chk_ok(t >= 3 * dv - 1 && t <= 3 * dv + 5);
      drain(10);
    end
    v = $urandom;
    bus(1, OFS_TIMER_ENTRY, {24'h000200, v});
    exp_q.push_back({3'h0, 3'h0, v});
    exp_q.push_back({3'h0, 3'h0, v});
    bus(1, OFS_TIMER_RELOAD_VALUE, 32'h0000_0028);
    drain(300);
    bus(1, OFS_TIMER_ENTRY, 32'h0003_0000);
    bus(1, OFS_TIMER_RELOAD_VALUE, 32'h8000_0000);
    bus(0, OFS_TIMER_PRESENT_VALUE, 0);
    chk_ok(q <= 32'h8000_0000 && q > 32'h7fff_ff00);
    bus(1, OFS_TIMER_PRESENT_VALUE, 0);
    bus(0, OFS_TIMER_PRESENT_VALUE, 0);
    chk_ok(q > 32'h7fff_ff00);
    // Clock enable low for 20 cycles must hold the count still
    bus(0, OFS_TIMER_PRESENT_VALUE, 0);
    cfg = q;
    ce <= 1'b0;
    repeat (20) @(posedge clk_i);
    ce <= 1'b1;
    bus(0, OFS_TIMER_PRESENT_VALUE, 0);
    chk_ok(cfg - q <= 32'h0000_0008 && cfg - q != 32'h0000_0000);
    end_sim();
  end
endmodule
bind lvt_top lvt_checker chk_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .intr_o(intr_o), .intr_valid_o(intr_valid_o), .intr_accept_i(intr_accept_i));

// >>> hw/lvt_pkg.sv
package lvt_pkg;

  // Entry indexes
  localparam int LVT_NUM = 7;
  localparam int ENT_TIMER = 0;
  localparam int ENT_THERMAL = 1;
  localparam int ENT_PERF = 2;
  localparam int ENT_INPUT0 = 3;
  localparam int ENT_INPUT1 = 4;
  localparam int ENT_ERROR = 5;
  localparam int ENT_THRESHOLD = 6;
  localparam int LVT_SRC_NUM = 6;

  // Register byte offsets
  localparam int LVT_AW = 11;
  localparam logic [LVT_AW-1:0] OFS_TIMER_ENTRY = 11'h320;
  localparam logic [LVT_AW-1:0] OFS_THERMAL_EVENT_ENTRY = 11'h330;
  localparam logic [LVT_AW-1:0] OFS_PERF_OVERFLOW_ENTRY = 11'h340;
  localparam logic [LVT_AW-1:0] OFS_LOCAL_INPUT0_ENTRY = 11'h350;
  localparam logic [LVT_AW-1:0] OFS_LOCAL_INPUT1_ENTRY = 11'h360;
  localparam logic [LVT_AW-1:0] OFS_ERROR_EVENT_ENTRY = 11'h370;
  localparam logic [LVT_AW-1:0] OFS_TIMER_RELOAD_VALUE = 11'h380;
  localparam logic [LVT_AW-1:0] OFS_TIMER_PRESENT_VALUE = 11'h390;
  localparam logic [LVT_AW-1:0] OFS_TIMER_PRESCALE_SELECT = 11'h3e0;
  localparam logic [LVT_AW-1:0] OFS_EXTENSION_CAPABILITY = 11'h400;
  localparam logic [LVT_AW-1:0] OFS_THRESHOLD_OVERFLOW_ENTRY = 11'h500;
  localparam logic [LVT_NUM-1:0][LVT_AW-1:0] LVT_ENTRY_OFS = {
    OFS_THRESHOLD_OVERFLOW_ENTRY, OFS_ERROR_EVENT_ENTRY, OFS_LOCAL_INPUT1_ENTRY,
    OFS_LOCAL_INPUT0_ENTRY, OFS_PERF_OVERFLOW_ENTRY, OFS_THERMAL_EVENT_ENTRY,
    OFS_TIMER_ENTRY};

  // Entry field positions
  localparam int BIT_TIMER_MODE = 17;
  localparam int BIT_MASK = 16;
  localparam int BIT_TRIGGER = 15;
  localparam int BIT_REMOTE = 14;
  localparam int BIT_POLARITY = 13;
  localparam int BIT_PENDING = 12;
  localparam int MSG_LSB = 8;
  localparam int VEC_LSB = 0;

  // Which entries carry which optional fields
  localparam logic [LVT_NUM-1:0] HAS_MSG = 7'h5e;
  localparam logic [LVT_NUM-1:0] HAS_LINE = 7'h18;

  // Prescale select bits, capability field
  localparam int BIT_DIV_HI = 3;
  localparam int BIT_DIV_MID = 1;
  localparam int BIT_DIV_LO = 0;
  localparam int CAPS_COUNT_LSB = 16;
  localparam logic [7:0] EXT_ENTRY_COUNT = 8'h01;
  localparam logic [31:0] RELOAD_RESET = 32'h0000_0000;

  typedef struct packed {
    logic timer_mode;
    logic mask;
    logic trigger_select;
    logic input_polarity;
    logic [2:0] msg_type;
    logic [7:0] vector;
  } lvt_cfg_type;

  localparam lvt_cfg_type CFG_RESET = '{mask: 1'b1, msg_type: 3'h0, vector: 8'h00,
                                        default: 1'b0};

  typedef struct packed {
    logic [2:0] source;
    logic [2:0] msg_type;
    logic [7:0] vector;
  } lvt_intr_type;

endpackage

// >>> hw/lvt_timer.sv
`timescale 1ns/10ps
module lvt_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Configuration
  input wire logic [2:0] div_sel_i,
  input wire logic periodic_i,
  input wire logic [31:0] reload_i,
  // Load strobe with value
  input wire logic load_i,
  input wire logic [31:0] load_value_i,
  // Count state
  output logic [31:0] count_o,
  output logic expire_o
);
  import lvt_pkg::*;

  logic [6:0] pre_cnt;
  logic [7:0] divisor;
  logic tick;

  // Code n gives 2^(n+1), wrapping so that 111 gives 1
  assign divisor = 8'h01 << 3'(div_sel_i + 3'h1);
  assign tick = (pre_cnt == 7'(divisor - 8'h01));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt <= 7'h00;
    end else if (ce_i) begin
      if (load_i || tick || count_o == 32'h0000_0000) begin
        pre_cnt <= 7'h00;
      end else begin
        pre_cnt <= pre_cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= 32'h0000_0000;
      expire_o <= 1'b0;
    end else if (ce_i) begin
      expire_o <= 1'b0;
      if (load_i) begin
        count_o <= load_value_i;
      end else if (tick && count_o != 32'h0000_0000) begin
        if (count_o == 32'h0000_0001) begin
          expire_o <= 1'b1;
          count_o <= periodic_i ? reload_i : 32'h0000_0000;
        end else begin
          count_o <= count_o - 32'h0000_0001;
        end
      end
    end
  end

endmodule

// >>> hw/lvt_top.sv
`timescale 1ns/10ps
module lvt_top (
  // Clock, reset, clock enable
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Avalon-MM slave
  input wire logic [lvt_pkg::LVT_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Event sources: thermal, perf, input0, input1, error, threshold
  input wire logic [lvt_pkg::LVT_SRC_NUM-1:0] src_i,
  // Core delivery and end of interrupt for the two local inputs
  output lvt_pkg::lvt_intr_type intr_o,
  output logic intr_valid_o,
  input wire logic intr_accept_i,
  input wire logic [1:0] eoi_i
);
  import lvt_pkg::*;

  logic rst_q1;
  logic rst_n;
  lvt_cfg_type cfg [LVT_NUM];
  logic pend_q [LVT_NUM];
  logic remote_q [LVT_NUM];
  logic src_q [LVT_NUM];
  logic [LVT_NUM-1:0] wr_entry;
  logic [31:0] reload_value;
  logic [2:0] div_sel;
  logic [31:0] present_value;
  logic timer_expire;
  logic [31:0] rd_word;
  logic [31:0] byte_mask;
  logic [31:0] wd;
  logic wr_fire;
  logic rd_take;
  logic found;
  logic [2:0] next_sel;

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  function automatic logic [31:0] entry_word(lvt_cfg_type c, logic p, logic r);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[BIT_TIMER_MODE] = c.timer_mode;
    w[BIT_MASK] = c.mask;
    w[BIT_TRIGGER] = c.trigger_select;
    w[BIT_REMOTE] = r;
    w[BIT_POLARITY] = c.input_polarity;
    w[BIT_PENDING] = p;
    w[MSG_LSB +: 3] = c.msg_type;
    w[VEC_LSB +: 8] = c.vector;
    return w;
  endfunction

  // Bus handshake: one wait cycle, then the answer
  assign wr_fire = ce_i && avs_write_i && !avs_waitrequest_o;
  assign rd_take = ce_i && avs_read_i && avs_waitrequest_o;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_o <= 1'b1;
    end else if (ce_i) begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
    end
  end

  // Read mux, unmapped addresses read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    for (int k = 0; k < LVT_NUM; k++) begin
      if (avs_address_i == LVT_ENTRY_OFS[k]) begin
        rd_word = entry_word(cfg[k], pend_q[k], remote_q[k]);
      end
    end
    case (avs_address_i)
      OFS_TIMER_RELOAD_VALUE: begin
        rd_word = reload_value;
      end
      OFS_TIMER_PRESENT_VALUE: begin
        rd_word = present_value;
      end
      OFS_TIMER_PRESCALE_SELECT: begin
        rd_word[BIT_DIV_HI] = div_sel[2];
        rd_word[BIT_DIV_MID] = div_sel[1];
        rd_word[BIT_DIV_LO] = div_sel[0];
      end
      OFS_EXTENSION_CAPABILITY: begin
        rd_word[CAPS_COUNT_LSB +: 8] = EXT_ENTRY_COUNT;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_take) begin
      avs_readdata_o <= rd_word;
    end
  end

  // Byte-lane merge of write data into the present contents
  assign byte_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wd = (rd_word & ~byte_mask) | (avs_writedata_i & byte_mask);

  // Timer reload value and prescale select
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reload_value <= RELOAD_RESET;
    end else if (wr_fire && avs_address_i == OFS_TIMER_RELOAD_VALUE) begin
      reload_value <= wd;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_sel <= 3'h0;
    end else if (wr_fire && avs_address_i == OFS_TIMER_PRESCALE_SELECT) begin
      div_sel <= {wd[BIT_DIV_HI], wd[BIT_DIV_MID], wd[BIT_DIV_LO]};
    end
  end

  lvt_timer u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .div_sel_i(div_sel),
    .periodic_i(cfg[ENT_TIMER].timer_mode),
    .reload_i(reload_value),
    .load_i(wr_fire && avs_address_i == OFS_TIMER_RELOAD_VALUE),
    .load_value_i(wd),
    .count_o(present_value),
    .expire_o(timer_expire)
  );

  // Per-entry configuration, pending and remote service state
  for (genvar i = 0; i < LVT_NUM; i++) begin : g_entry
    logic src_now;
    logic fire;
    logic accepted;
    logic eoi_hit;

    if (i == ENT_TIMER) begin : g_tsrc
      assign src_now = timer_expire;
      assign fire = timer_expire;
    end else begin : g_xsrc
      assign src_now = src_i[i-1];
      // Level mode fires on the level while not in service; edge mode on a rise
      assign fire = (HAS_LINE[i] && cfg[i].trigger_select) ?
                    (src_now && !remote_q[i] && !pend_q[i]) :
                    (src_now && !src_q[i]);
    end

    if (HAS_LINE[i]) begin : g_eoi
      assign eoi_hit = eoi_i[i-ENT_INPUT0];
    end else begin : g_noeoi
      assign eoi_hit = 1'b0;
    end

    assign wr_entry[i] = wr_fire && avs_address_i == LVT_ENTRY_OFS[i];
    assign accepted = intr_valid_o && intr_accept_i && intr_o.source == 3'(i);

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        src_q[i] <= 1'b0;
      end else if (ce_i) begin
        src_q[i] <= src_now;
      end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        cfg[i] <= CFG_RESET;
      end else if (ce_i && wr_entry[i]) begin
        cfg[i].mask <= wd[BIT_MASK];
        cfg[i].vector <= wd[VEC_LSB +: 8];
        // Fields absent from an entry stay zero
        if (HAS_MSG[i]) begin
          cfg[i].msg_type <= wd[MSG_LSB +: 3];
        end
        if (HAS_LINE[i]) begin
          cfg[i].trigger_select <= wd[BIT_TRIGGER];
          cfg[i].input_polarity <= wd[BIT_POLARITY];
        end
        if (i == ENT_TIMER) begin
          cfg[i].timer_mode <= wd[BIT_TIMER_MODE];
        end
      end
    end

    // A new event wins over the acceptance clear in the same cycle
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        pend_q[i] <= 1'b0;
      end else if (ce_i) begin
        pend_q[i] <= (fire && !cfg[i].mask) || (pend_q[i] && !accepted);
      end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        remote_q[i] <= 1'b0;
      end else if (ce_i) begin
        if (HAS_LINE[i] && accepted && cfg[i].trigger_select) begin
          remote_q[i] <= 1'b1;
        end else if (eoi_hit) begin
          remote_q[i] <= 1'b0;
        end
      end
    end
  end

  // Lowest index wins among unmasked pending entries
  always_comb begin
    found = 1'b0;
    next_sel = 3'h0;
    for (int k = LVT_NUM - 1; k >= 0; k--) begin
      if (pend_q[k] && !cfg[k].mask) begin
        found = 1'b1;
        next_sel = 3'(k);
      end
    end
  end

  // Delivery to the core, held until accepted
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      intr_valid_o <= 1'b0;
      intr_o <= '0;
    end else if (ce_i) begin
      if (intr_valid_o) begin
        if (intr_accept_i) begin
          intr_valid_o <= 1'b0;
        end
      end else if (found) begin
        intr_valid_o <= 1'b1;
        intr_o.source <= next_sel;
        intr_o.msg_type <= cfg[next_sel].msg_type;
        intr_o.vector <= cfg[next_sel].vector;
      end
    end
  end

endmodule
